/* design/ddr_ctl_end.sv */
// Purpose: Controller end: issues pin commands and moves burst data
// Assumes: Link clock is clk_sys divided by two
// Notes:   Pins change on link clock fall, device samples on rise
//
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
module ddr_ctl_end
#(
  parameter int RD_TIMEOUT = 32
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [ddr_pin_pkg::REG_AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  ddr_link_if.ctl lnk
);
  import ddr_pin_pkg::*;

  if (RD_TIMEOUT < 12 || RD_TIMEOUT > 255)
  begin : g_bad_timeout
    $error("RD_TIMEOUT out of range");
  end

  ctl_state_t state_ff;
  logic ck_ff;
  logic [2:0] ctrl_ff;
  logic [ADDR_BANK_LSB+BANK_W-1:0] addr_ff;
  logic [15:0] mask_ff;
  logic [DATA_W-1:0] wdata_ff [8];
  logic [DATA_W-1:0] rdata_ff [8];
  logic [2:0] op_ff;
  logic rdone_ff;
  logic tmo_ff;
  logic [3:0] beat_ff;
  logic [3:0] nbeats_ff;
  logic [7:0] tmo_cnt_ff;
  logic [LANES-1:0] rprev_ff;
  logic [31:0] rdata_out_ff;
  logic [3:0] cmd_ff;
  logic [BANK_W-1:0] ba_ff;
  logic [ADDR_W-1:0] a_ff;
  logic [LANES-1:0] mpin_ff;
  logic [2:0] side_ff;
  logic [DATA_W-1:0] dat_ff;
  logic [LANES-1:0] stb_ff;
  logic oe_ff;
  logic tick;
  logic [7:0] woff;
  logic [7:0] roff;
  logic w_in;
  logic r_in;
  logic [LANES-1:0] stb_in;

  assign tick = ck_ff;
  assign woff = reg_addr - REG_WDATA;
  assign roff = reg_addr - REG_RDATA;
  assign w_in = (reg_addr >= REG_WDATA) & (reg_addr < REG_RDATA);
  assign r_in = (reg_addr >= REG_RDATA) & (reg_addr < REG_END);
  assign stb_in = {lnk.upper_byte_strobe, lnk.lower_byte_strobe};

  // ----------------------------------------------------------------------
  // Link clock divider
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      ck_ff <= 1'b0;
    else
      ck_ff <= ~ck_ff;
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      ctrl_ff <= CTRL_RST;
      addr_ff <= '0;
      mask_ff <= '0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == REG_CTRL)
        ctrl_ff <= reg_wdata[2:0];
      if (reg_addr == REG_ADDR)
        addr_ff <= reg_wdata[ADDR_BANK_LSB+BANK_W-1:0];
      if (reg_addr == REG_MASK)
        mask_ff <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reg_wr & w_in & (woff[1:0] == 2'h0))
      wdata_ff[woff[4:2]] <= reg_wdata[DATA_W-1:0];
  end

  // ----------------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata_out_ff <= '0;
    else if (reg_rd)
    begin
      rdata_out_ff <= '0;
      if (reg_addr == REG_CTRL)
        rdata_out_ff <= {29'h0, ctrl_ff};
      else if (reg_addr == REG_ADDR)
        rdata_out_ff <= {13'h0, addr_ff};
      else if (reg_addr == REG_CMD)
        rdata_out_ff <= {29'h0, tmo_ff, rdone_ff, state_ff != ST_IDLE};
      else if (reg_addr == REG_MASK)
        rdata_out_ff <= {16'h0, mask_ff};
      else if (w_in & (woff[1:0] == 2'h0))
        rdata_out_ff <= {16'h0, wdata_ff[woff[4:2]]};
      else if (r_in & (roff[1:0] == 2'h0))
        rdata_out_ff <= {16'h0, rdata_ff[roff[4:2]]};
    end
  end

  assign reg_rdata = rdata_out_ff;

  // ----------------------------------------------------------------------
  // Sequencer and pin drive
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      state_ff <= ST_IDLE;
      op_ff <= '0;
      rdone_ff <= 1'b0;
      tmo_ff <= 1'b0;
      beat_ff <= '0;
      nbeats_ff <= BEATS_FULL;
      tmo_cnt_ff <= '0;
      rprev_ff <= '0;
      cmd_ff <= CMD_DESEL;
      ba_ff <= '0;
      a_ff <= '0;
      mpin_ff <= '0;
      side_ff <= 3'h1; // Device held in clear while srst
      dat_ff <= '0;
      stb_ff <= '0;
      oe_ff <= 1'b0;
    end
    else
    begin
      if (tick)
        // Clear pin stays high unless software asks for a reset
        side_ff <= {~ctrl_ff[CTRL_CLR_BIT], ctrl_ff[CTRL_TERM_BIT],
                    ctrl_ff[CTRL_GATE_BIT]};
      case (state_ff)
        ST_IDLE:
        begin
          if (tick)
            cmd_ff <= CMD_DESEL;
          if (reg_wr & (reg_addr == REG_CMD) &
              (reg_wdata[2:0] >= OP_ACT) & (reg_wdata[2:0] <= OP_WR))
          begin
            op_ff <= reg_wdata[2:0];
            rdone_ff <= 1'b0;
            tmo_ff <= 1'b0;
            state_ff <= ST_ISSUE;
          end
        end
        ST_ISSUE:
        begin
          if (tick)
          begin
            ba_ff <= addr_ff[ADDR_BANK_LSB +: BANK_W];
            a_ff <= addr_ff[ADDR_W-1:0];
            beat_ff <= '0;
            tmo_cnt_ff <= '0;
            rprev_ff <= stb_in;
            nbeats_ff <= addr_ff[BC_BIT] ? BEATS_FULL : BEATS_CHOP;
            case (op_ff)
              OP_ACT: cmd_ff <= CMD_ACT;
              OP_PRE: cmd_ff <= CMD_PRE;
              OP_RD: cmd_ff <= CMD_RD;
              default: cmd_ff <= CMD_WR;
            endcase
            state_ff <= (op_ff == OP_WR) ? ST_WBURST :
                        (op_ff == OP_RD) ? ST_RBURST : ST_IDLE;
          end
        end
        ST_WBURST:
        begin
          if (tick)
          begin
            cmd_ff <= CMD_NOP;
            if (beat_ff == nbeats_ff)
            begin
              oe_ff <= 1'b0;
              stb_ff <= '0;
              mpin_ff <= '0;
              state_ff <= ST_IDLE;
            end
            else
            begin
              // One word per strobe edge, mask alongside
              oe_ff <= 1'b1;
              stb_ff <= ~stb_ff;
              dat_ff <= wdata_ff[beat_ff[2:0]];
              mpin_ff <= mask_ff[2*beat_ff[2:0] +: 2];
              beat_ff <= beat_ff + 4'h1;
            end
          end
        end
        ST_RBURST:
        begin
          if (tick)
          begin
            cmd_ff <= CMD_NOP;
            rprev_ff <= stb_in;
            tmo_cnt_ff <= tmo_cnt_ff + 8'h1;
            if (stb_in[0] != rprev_ff[0])
            begin
              rdata_ff[beat_ff[2:0]] <= lnk.data_lines;
              beat_ff <= beat_ff + 4'h1;
              if (beat_ff + 4'h1 == nbeats_ff)
              begin
                rdone_ff <= 1'b1;
                state_ff <= ST_IDLE;
              end
            end
            else if (tmo_cnt_ff == 8'(RD_TIMEOUT))
            begin
              tmo_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  assign lnk.ck = ck_ff;
  assign {lnk.chip_select_n, lnk.row_strobe_n, lnk.column_strobe_n,
          lnk.write_select_n} = cmd_ff;
  assign lnk.bank_select = ba_ff;
  assign lnk.addr = a_ff;
  assign {lnk.upper_byte_mask, lnk.lower_byte_mask} = mpin_ff;
  assign {lnk.async_clear_n, lnk.termination_enable, lnk.clock_gate} = side_ff;
  assign lnk.ctl_dat_o = dat_ff;
  assign lnk.ctl_dat_oe = oe_ff;
  assign lnk.ctl_stb_o = stb_ff;
  assign lnk.ctl_stb_n_o = ~stb_ff;
  assign lnk.ctl_stb_oe = oe_ff;
endmodule

/* include/ddr_pin_pkg.sv */
// Purpose: Shared constants for the memory pin decoder and its controller
// Assumes: 16-bit data on two byte lanes, eight banks
// Notes:   Command codes are {select_n, row_n, column_n, write_n}
package ddr_pin_pkg;
  // ----------------------------------------------------------------------
  // Pin widths and field positions
  // ----------------------------------------------------------------------
  localparam int DATA_W = 16;
  localparam int LANES = 2;
  localparam int BANK_W = 3;
  localparam int NUM_BANKS = 8;
  localparam int ADDR_W = 13;
  localparam int AP_BIT = 10;
  localparam int BC_BIT = 12;
  localparam int COL_W = 3;
  localparam int MEM_IDX_W = 6;
  localparam logic [3:0] BEATS_FULL = 4'h8;
  localparam logic [3:0] BEATS_CHOP = 4'h4;

  // ----------------------------------------------------------------------
  // Pin command codes
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'hF;

  // ----------------------------------------------------------------------
  // Controller register map
  // ----------------------------------------------------------------------
  localparam int REG_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_MASK = 8'h0C;
  localparam logic [7:0] REG_WDATA = 8'h10;
  localparam logic [7:0] REG_RDATA = 8'h30;
  localparam logic [7:0] REG_END = 8'h50;
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_TERM_BIT = 1;
  localparam int CTRL_CLR_BIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h1;
  localparam int ADDR_BANK_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDONE_BIT = 1;
  localparam int STAT_TMO_BIT = 2;
  localparam logic [2:0] OP_ACT = 3'h1;
  localparam logic [2:0] OP_PRE = 3'h2;
  localparam logic [2:0] OP_RD = 3'h3;
  localparam logic [2:0] OP_WR = 3'h4;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ISSUE = 4'h2,
    ST_WBURST = 4'h4,
    ST_RBURST = 4'h8
  } ctl_state_t;
endpackage

/* include/ddr_link_if.sv */
// Purpose: Pin bundle between memory controller and memory device
// Assumes: Controller makes the link clock
// Notes:   Undriven strobes park low (true) and high (complement)
`timescale 1ns/1ps
interface ddr_link_if;
  import ddr_pin_pkg::*;
  logic ck;
  logic chip_select_n;
  logic row_strobe_n;
  logic column_strobe_n;
  logic write_select_n;
  logic [BANK_W-1:0] bank_select;
  logic [ADDR_W-1:0] addr;
  logic lower_byte_mask;
  logic upper_byte_mask;
  logic termination_enable;
  logic clock_gate;
  logic async_clear_n;
  logic [DATA_W-1:0] ctl_dat_o;
  logic ctl_dat_oe;
  logic [LANES-1:0] ctl_stb_o;
  logic [LANES-1:0] ctl_stb_n_o;
  logic ctl_stb_oe;
  logic [DATA_W-1:0] dev_dat_o;
  logic dev_dat_oe;
  logic [LANES-1:0] dev_stb_o;
  logic [LANES-1:0] dev_stb_n_o;
  logic dev_stb_oe;
  logic [DATA_W-1:0] data_lines;
  logic lower_byte_strobe;
  logic upper_byte_strobe;
  logic lower_byte_strobe_n;
  logic upper_byte_strobe_n;

  // ----------------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------------
  assign data_lines = dev_dat_oe ? dev_dat_o : ctl_dat_oe ? ctl_dat_o : '0;
  assign lower_byte_strobe = dev_stb_oe ? dev_stb_o[0] :
                             ctl_stb_oe & ctl_stb_o[0];
  assign upper_byte_strobe = dev_stb_oe ? dev_stb_o[1] :
                             ctl_stb_oe & ctl_stb_o[1];
  assign lower_byte_strobe_n = dev_stb_oe ? dev_stb_n_o[0] :
                               ~ctl_stb_oe | ctl_stb_n_o[0];
  assign upper_byte_strobe_n = dev_stb_oe ? dev_stb_n_o[1] :
                               ~ctl_stb_oe | ctl_stb_n_o[1];

  modport dev (
    input ck, chip_select_n, row_strobe_n, column_strobe_n, write_select_n,
    input bank_select, addr, lower_byte_mask, upper_byte_mask,
    input termination_enable, clock_gate, async_clear_n, data_lines,
    input lower_byte_strobe, upper_byte_strobe,
    input lower_byte_strobe_n, upper_byte_strobe_n,
    output dev_dat_o, dev_dat_oe, dev_stb_o, dev_stb_n_o, dev_stb_oe
  );
  modport ctl (
    output ck, chip_select_n, row_strobe_n, column_strobe_n, write_select_n,
    output bank_select, addr, lower_byte_mask, upper_byte_mask,
    output termination_enable, clock_gate, async_clear_n,
    output ctl_dat_o, ctl_dat_oe, ctl_stb_o, ctl_stb_n_o, ctl_stb_oe,
    input data_lines, lower_byte_strobe, upper_byte_strobe,
    input lower_byte_strobe_n, upper_byte_strobe_n
  );
endinterface

/* design/ddr_dev_end.sv */
// Purpose: Memory device end: command decode, bank state, byte lanes
// Assumes: All link inputs change half a link clock before its rise
// Notes:   Small flop array stands in for the cell array
//
// Summary of operation
// - Read/write address bit 10 selects auto precharge
// - Precharge bit 10: one bank or all
// - Read/write address bit 12 low chops burst
// - Commands taken only with chip select low
// - Row open command activates addressed bank
// - Precharge command closes addressed bank
// - Column access: read or write by write select
// - Byte mask high discards that lane's write data
// - Each byte lane has its own strobe pair
// - Data moves on both strobe edges
// - Read strobe edge aligned; write strobe times data
// - Registered termination enable switches termination on
// - Termination enable ignored when both settings off
// - Clear input resets asynchronously while low
// - Controller holds clear high in normal operation
// - Clock gate low freezes bank and burst state from next cycle
// - Bank select picks one of eight banks
`timescale 1ns/1ps
module ddr_dev_end
(
  ddr_link_if.dev lnk,
  input wire logic [2:0] mode_reg_one_term,
  input wire logic [1:0] mode_reg_two_term,
  output logic [ddr_pin_pkg::NUM_BANKS-1:0] bank_open,
  output logic term_on,
  output logic burst_busy
);
  import ddr_pin_pkg::*;

  logic clr_n;
  logic run_ff;
  logic [NUM_BANKS-1:0] bank_open_ff;
  logic [NUM_BANKS-1:0] nxt_bank_open;
  logic [2:0] mr1_meta_ff;
  logic [2:0] mr1_sync_ff;
  logic [1:0] mr2_meta_ff;
  logic [1:0] mr2_sync_ff;
  logic term_on_ff;
  logic busy_ff;
  logic dir_wr_ff;
  logic ap_ff;
  logic [BANK_W-1:0] bank_ff;
  logic [COL_W-1:0] col_ff;
  logic [3:0] beat_ff;
  logic [3:0] beats_ff;
  logic [LANES-1:0] stb_prev_ff;
  logic [DATA_W-1:0] dat_ff;
  logic [LANES-1:0] stb_ff;
  logic oe_ff;
  logic [3:0] cmd_code;
  logic cmd_ok;
  logic is_act;
  logic is_pre;
  logic is_rd;
  logic is_wr;
  logic col_go;
  logic [LANES-1:0] stb_now;
  logic [LANES-1:0] stb_edge;
  logic [LANES-1:0] mask_now;
  logic step;
  logic last;
  logic [MEM_IDX_W-1:0] mem_idx;
  logic [DATA_W-1:0] rd_word;

  assign clr_n = lnk.async_clear_n;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  // Select is the top bit of every code, so a high select matches none
  assign cmd_code = {lnk.chip_select_n, lnk.row_strobe_n,
                     lnk.column_strobe_n, lnk.write_select_n};
  // Gate must be high on this and the previous sample
  assign cmd_ok = run_ff & lnk.clock_gate;
  assign is_act = cmd_ok & (cmd_code == CMD_ACT);
  assign is_pre = cmd_ok & (cmd_code == CMD_PRE);
  assign is_rd = cmd_ok & (cmd_code == CMD_RD);
  assign is_wr = cmd_ok & (cmd_code == CMD_WR);
  // Any other select-low code leaves banks and bursts untouched
  assign col_go = (is_rd | is_wr) & ~busy_ff &
                  bank_open_ff[lnk.bank_select];

  assign stb_now = {lnk.upper_byte_strobe, lnk.lower_byte_strobe};
  assign mask_now = {lnk.upper_byte_mask, lnk.lower_byte_mask};
  // Every change of level, rising or falling, marks one word
  assign stb_edge = stb_now ^ stb_prev_ff;
  assign step = dir_wr_ff ? stb_edge[0] : 1'b1;
  assign last = busy_ff & run_ff & step & (beat_ff == beats_ff - 4'h1);
  assign mem_idx = {bank_ff, 3'(col_ff + beat_ff[2:0])};

  // ----------------------------------------------------------------------
  // Clock suspend
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.ck or negedge clr_n)
  begin
    if (!clr_n)
      run_ff <= 1'b1;
    else
      run_ff <= lnk.clock_gate;
  end

  // ----------------------------------------------------------------------
  // Bank state
  // ----------------------------------------------------------------------
  always_comb
  begin
    nxt_bank_open = bank_open_ff;
    if (last & ap_ff)
      nxt_bank_open[bank_ff] = 1'b0;
    if (is_act)
      nxt_bank_open[lnk.bank_select] = 1'b1;
    else if (is_pre)
    begin
      if (lnk.addr[AP_BIT])
        nxt_bank_open = '0;
      else
        nxt_bank_open[lnk.bank_select] = 1'b0;
    end
  end

  always_ff @(posedge lnk.ck or negedge clr_n)
  begin
    if (!clr_n)
      bank_open_ff <= '0;
    else
      bank_open_ff <= nxt_bank_open;
  end

  // ----------------------------------------------------------------------
  // Termination
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.ck or negedge clr_n)
  begin
    if (!clr_n)
    begin
      mr1_meta_ff <= '0;
      mr1_sync_ff <= '0;
      mr2_meta_ff <= '0;
      mr2_sync_ff <= '0;
      term_on_ff <= 1'b0;
    end
    else
    begin
      mr1_meta_ff <= mode_reg_one_term;
      mr1_sync_ff <= mr1_meta_ff;
      mr2_meta_ff <= mode_reg_two_term;
      mr2_sync_ff <= mr2_meta_ff;
      term_on_ff <= lnk.termination_enable &
                    ((mr1_sync_ff != '0) | (mr2_sync_ff != '0));
    end
  end

  // ----------------------------------------------------------------------
  // Burst sequencing
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.ck or negedge clr_n)
  begin
    if (!clr_n)
    begin
      busy_ff <= 1'b0;
      dir_wr_ff <= 1'b0;
      ap_ff <= 1'b0;
      bank_ff <= '0;
      col_ff <= '0;
      beat_ff <= '0;
      beats_ff <= BEATS_FULL;
    end
    else if (col_go)
    begin
      busy_ff <= 1'b1;
      dir_wr_ff <= is_wr;
      ap_ff <= lnk.addr[AP_BIT];
      bank_ff <= lnk.bank_select;
      col_ff <= lnk.addr[COL_W-1:0];
      beat_ff <= '0;
      beats_ff <= lnk.addr[BC_BIT] ? BEATS_FULL : BEATS_CHOP;
    end
    else if (last)
      busy_ff <= 1'b0;
    else if (busy_ff & run_ff & step)
      beat_ff <= beat_ff + 4'h1;
  end

  always_ff @(posedge lnk.ck or negedge clr_n)
  begin
    if (!clr_n)
      stb_prev_ff <= '0;
    else if (run_ff)
      stb_prev_ff <= stb_now;
  end

  // ----------------------------------------------------------------------
  // Byte lane storage
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    logic [7:0] mem [2**MEM_IDX_W];
    always_ff @(posedge lnk.ck)
    begin
      // Write strobe edge times data and mask; mask high drops the byte
      if (busy_ff & dir_wr_ff & run_ff & stb_edge[i] & ~mask_now[i])
        mem[mem_idx] <= lnk.data_lines[8*i +: 8];
    end
    assign rd_word[8*i +: 8] = mem[mem_idx];
  end

  // ----------------------------------------------------------------------
  // Read drive
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.ck or negedge clr_n)
  begin
    if (!clr_n)
    begin
      oe_ff <= 1'b0;
      stb_ff <= '0;
      dat_ff <= '0;
    end
    else if (run_ff)
    begin
      if (busy_ff & ~dir_wr_ff)
      begin
        // Strobe flips in the same edge as the data changes
        oe_ff <= 1'b1;
        stb_ff <= ~stb_ff;
        dat_ff <= rd_word;
      end
      else
      begin
        oe_ff <= 1'b0;
        stb_ff <= '0;
        dat_ff <= '0;
      end
    end
  end

  assign lnk.dev_dat_o = dat_ff;
  assign lnk.dev_dat_oe = oe_ff;
  assign lnk.dev_stb_o = stb_ff;
  assign lnk.dev_stb_n_o = ~stb_ff;
  assign lnk.dev_stb_oe = oe_ff;
  assign bank_open = bank_open_ff;
  assign term_on = term_on_ff;
  assign burst_busy = busy_ff;
endmodule

/* dv/ddr_link_checker.sv */
// Purpose: Link pin assertions
// Assumes: Pins sampled on link clock rise
// Notes:   Watches pins and device status
`timescale 1ns/1ps
module ddr_link_checker
(
  input wire logic ck,
  input wire logic async_clear_n,
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic column_strobe_n,
  input wire logic write_select_n,
  input wire logic [ddr_pin_pkg::BANK_W-1:0] bank_select,
  input wire logic [ddr_pin_pkg::ADDR_W-1:0] addr,
  input wire logic clock_gate,
  input wire logic termination_enable,
  input wire logic dev_dat_oe,
  input wire logic lower_byte_strobe,
  input wire logic lower_byte_strobe_n,
  input wire logic upper_byte_strobe,
  input wire logic [ddr_pin_pkg::NUM_BANKS-1:0] bank_open,
  input wire logic term_on,
  input wire logic burst_busy,
  input wire logic [2:0] mode_reg_one_term,
  input wire logic [1:0] mode_reg_two_term
);
  import ddr_pin_pkg::*;
  // ----
  // Command view
  // ----
  logic gate_q;
  logic [3:0] cmd;
  logic take;
  logic ap;
  logic want;
  assign cmd = {chip_select_n, row_strobe_n, column_strobe_n, write_select_n};
  assign take = clock_gate & gate_q;
  assign ap = addr[AP_BIT];
  assign want = termination_enable & (|mode_reg_one_term | |mode_reg_two_term);
  always_ff @(posedge ck) gate_q <= clock_gate;
  default clocking cb @(posedge ck); endclocking
  default disable iff (!async_clear_n);
  property p_desel; chip_select_n && !burst_busy |=> $stable(bank_open);
  endproperty
  a_desel: assert property (p_desel) else $error("desel");
  property p_act; take && cmd == CMD_ACT |=> bank_open[$past(bank_select)];
  endproperty
  a_act: assert property (p_act) else $error("act");
  property p_pre1; take && cmd == CMD_PRE && !ap
    |=> !bank_open[$past(bank_select)]; endproperty
  a_pre1: assert property (p_pre1) else $error("pre1");
  property p_prea; take && cmd == CMD_PRE && ap |=> bank_open == '0;
  endproperty
  a_prea: assert property (p_prea) else $error("prea");
  property p_bl8; take && cmd == CMD_RD && bank_open[bank_select] &&
    addr[BC_BIT] |=> ##1 dev_dat_oe [*8] ##1 !dev_dat_oe; endproperty
  a_bl8: assert property (p_bl8) else $error("bl8");
  property p_bc4; take && cmd == CMD_RD && bank_open[bank_select] &&
    !addr[BC_BIT] |=> ##1 dev_dat_oe [*4] ##1 !dev_dat_oe; endproperty
  a_bc4: assert property (p_bc4) else $error("bc4");
  property p_ap; take && cmd == CMD_RD && bank_open[bank_select] &&
    addr[BC_BIT] |=> ##10 bank_open[$past(bank_select, 11)] == !$past(ap, 11);
  endproperty
  a_ap: assert property (p_ap) else $error("ap");
  property p_stb; dev_dat_oe && $past(dev_dat_oe) |-> lower_byte_strobe !=
    $past(lower_byte_strobe) && lower_byte_strobe_n == !lower_byte_strobe &&
    upper_byte_strobe == lower_byte_strobe; endproperty
  a_stb: assert property (p_stb) else $error("stb");
  property p_term; take && mode_reg_one_term == $past(mode_reg_one_term, 4) &&
    mode_reg_two_term == $past(mode_reg_two_term, 4)
    |=> term_on == $past(want); endproperty
  a_term: assert property (p_term) else $error("term");
  property p_clr; $rose(async_clear_n) |-> bank_open == '0 && !dev_dat_oe;
  endproperty
  a_clr: assert property (p_clr) else $error("clr");
  property p_gate; !clock_gate && !gate_q |=> $stable(bank_open) &&
    $stable(dev_dat_oe); endproperty
  a_gate: assert property (p_gate) else $error("gate");
endmodule

/* dv/sdram_pin_command_decode_tb_top.sv */
// Purpose: Bench joining controller and device ends
// Assumes: Link clock made inside the controller
// Notes:   Register bus driven by NBA after clock rise
`timescale 1ns/1ps
module sdram_pin_command_decode_tb_top;
  import ddr_pin_pkg::*;
  localparam logic [15:0] MK = 16'h9E24;
  logic clk_sys = 0, srst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = '0, bank_open;
  logic [31:0] reg_wdata = '0, reg_rdata, d;
  logic [2:0] mr_one = '0;
  logic [1:0] mr_two = '0;
  logic term_on, burst_busy;
  int n_fail = 0, num_checks = 0, cyc = 0;
  ddr_link_if lnk ();
  ddr_ctl_end #(.RD_TIMEOUT(16)) ddr_ctl_end_i (.clk_sys(clk_sys),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lnk(lnk));
  ddr_dev_end ddr_dev_end_i (.lnk(lnk), .mode_reg_one_term(mr_one),
    .mode_reg_two_term(mr_two), .bank_open(bank_open), .term_on(term_on),
    .burst_busy(burst_busy));
  ddr_link_checker ddr_link_checker_i (.ck(lnk.ck),
    .async_clear_n(lnk.async_clear_n), .chip_select_n(lnk.chip_select_n),
    .row_strobe_n(lnk.row_strobe_n), .column_strobe_n(lnk.column_strobe_n),
    .write_select_n(lnk.write_select_n), .bank_select(lnk.bank_select),
    .addr(lnk.addr), .clock_gate(lnk.clock_gate),
    .termination_enable(lnk.termination_enable), .dev_dat_oe(lnk.dev_dat_oe),
    .lower_byte_strobe(lnk.lower_byte_strobe),
    .lower_byte_strobe_n(lnk.lower_byte_strobe_n),
    .upper_byte_strobe(lnk.upper_byte_strobe), .bank_open(bank_open),
    .term_on(term_on), .burst_busy(burst_busy),
    .mode_reg_one_term(mr_one), .mode_reg_two_term(mr_two));
  // ----
  // Bus tasks
  // ----
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  task automatic op(logic [2:0] o, logic [2:0] b, logic [12:0] a);
    wr(REG_ADDR, {13'h0, b, 3'h0, a});
    wr(REG_CMD, {29'h0, o});
    d = 32'h1;
    for (int i = 0; i < 100 && d[0] !== 1'b0; i++)
      rd(REG_CMD);
  endtask
  task automatic words(int n);
    logic [15:0] a, b;
    for (int i = 0; i < n; i++)
    begin
      a = 16'hA050 + 16'h0101 * 16'(i);
      b = 16'h3C3C ^ 16'(i);
      rd(REG_RDATA + 8'(4 * i));
      a = {MK[2*i+1] ? a[15:8] : b[15:8], MK[2*i] ? a[7:0] : b[7:0]};
      chk("word", d, {16'h0, a});
    end
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_data();
    rd(REG_CTRL);
    chk("ctrl", d, 32'h1);
    rd(REG_END);
    chk("unmapped", d, 32'h0);
    op(OP_ACT, 3'h3, 13'h0);
    chk("open", bank_open, 8'h08);
    wr(REG_MASK, 32'h0);
    for (int i = 0; i < 8; i++)
      wr(REG_WDATA + 8'(4 * i), {16'h0, 16'hA050 + 16'h0101 * 16'(i)});
    op(OP_WR, 3'h3, 13'h1005);
    wr(REG_MASK, {16'h0, MK});
    for (int i = 0; i < 8; i++)
      wr(REG_WDATA + 8'(4 * i), {16'h0, 16'h3C3C ^ 16'(i)});
    op(OP_WR, 3'h3, 13'h1005);
    op(OP_RD, 3'h3, 13'h1005);
    chk("stat", d, 32'h2);
    words(8);
    chk("kept", bank_open, 8'h08);
    op(OP_RD, 3'h3, 13'h0405);
    words(4);
    chk("autopre", bank_open, 8'h00);
    op(OP_RD, 3'h3, 13'h1005);
    chk("closed", d, 32'h4);
    $display("t_data done");
  endtask
  task automatic t_pre();
    op(OP_ACT, 3'h1, 13'h0);
    op(OP_ACT, 3'h6, 13'h0);
    op(OP_PRE, 3'h1, 13'h0);
    chk("pre1", bank_open, 8'h40);
    op(OP_ACT, 3'h2, 13'h0);
    op(OP_PRE, 3'h0, 13'h0400);
    chk("prea", bank_open, 8'h00);
    $display("t_pre done");
  endtask
  task automatic t_misc();
    wr(REG_CTRL, 32'h3);
    repeat (20) @(posedge clk_sys);
    chk("term_off", term_on, 32'h0);
    mr_one <= 3'h1;
    repeat (20) @(posedge clk_sys);
    chk("term_on", term_on, 32'h1);
    wr(REG_CTRL, 32'h0);
    op(OP_ACT, 3'h5, 13'h0);
    chk("gated", bank_open, 8'h00);
    wr(REG_CTRL, 32'h1);
    op(OP_ACT, 3'h7, 13'h0);
    chk("act7", bank_open, 8'h80);
    wr(REG_CTRL, 32'h5);
    repeat (6) @(posedge clk_sys);
    chk("clear", bank_open, 8'h00);
    wr(REG_CTRL, 32'h1);
    repeat (8) @(posedge clk_sys);
    $display("t_misc done");
  endtask
  initial
  begin
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_sim();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    t_data();
    t_pre();
    t_misc();
    end_sim();
  end
endmodule
